// [nce_map.vh]
// Purpose: Opcodes, field positions and counts for the nibble execute core.
// Assumes: Included by nce_core.v only.
// Notes:   Opcode bytes are matched with casez against the first instruction byte.
`ifndef NCE_MAP_VH
`define NCE_MAP_VH
`define NCE_CYCLE_DIV      8'd4
`define NCE_PC_W           11
`define NCE_OP_LOAD        8'b0010_0001
`define NCE_OP_XMOD        8'b1010_0???
`define NCE_OP_XINC        8'b1111_1110
`define NCE_OP_XDEC        8'b1111_1111
`define NCE_OP_TABLE       8'b0110_0011
`define NCE_OP_LDZ         8'b1000_????
`define NCE_OP_PINC        8'b1110_1110
`define NCE_OP_PDEC        8'b1110_1111
`define NCE_OP_XACC        8'b1110_00??
`define NCE_OP_XHIGH       8'b1111_?100
`define NCE_OP_XLOW        8'b1111_?000
`define NCE_OP_BFSET       8'b1101_????
`define NCE_OP_BFCLR       8'b1001_????
`define NCE_OP_LJMP        8'b0110_1???
`define NCE_OP_CJMP        8'b1111_1010
`define NCE_OP_ZCALL       8'b1011_????
`define NCE_OP_LCALL       8'b1010_1???
`define NCE_OP_RET         8'b0110_0010
`define NCE_OP_RETI        8'b0100_0010
`define NCE_OP_BTSET       8'b0111_1100
`define NCE_OP_BTCLR       8'b0011_1100
`define NCE_OP_BRSET       8'b0111_1101
`define NCE_OP_BRCLR       8'b0011_1101
`define NCE_OP_BCSET       8'b0111_1111
`define NCE_OP_BCCLR       8'b0011_1111
`define NCE_OP_BZSET       8'b0111_1110
`define NCE_OP_BZCLR       8'b0011_1110
`define NCE_OP_PBSET       8'b0000_01??
`define NCE_OP_PBRST       8'b0010_01??
`define NCE_OP_CSET        8'b0001_1100
`define NCE_OP_CRST        8'b0010_1100
`define NCE_OP_TWRITE      8'b1111_1001
`define NCE_OP_LIMM        8'b1100_????
`endif

// [nce_sync.v]
// Purpose: Two flip-flop synchroniser for asynchronous levels.
// Assumes: Destination clock is clk_in.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
module nce_sync #(
    parameter W   = 1,
    parameter RST = 1'b0
) (
    input  wire         clk_in,
    input  wire         nrst_in,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] hold_ff;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_ff <= {W{RST}};
            hold_ff <= {W{RST}};
        end else begin
            meta_ff <= d_in;
            hold_ff <= meta_ff;
        end
    end
    assign q_out = hold_ff;
endmodule

// [nce_tick.v]
// Purpose: Machine-cycle enable divider.
// Assumes: DIV is at least 1.
// Notes:   Emits a one-cycle pulse every DIV clocks.
`timescale 1ns/100ps
module nce_tick #(
    parameter [7:0] DIV = 8'd4
) (
    input  wire clk_in,
    input  wire nrst_in,
    output reg  tick_out
);
    reg [7:0] cnt_ff;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_ff   <= 8'h00;
            tick_out <= 1'b0;
        end else if (cnt_ff >= DIV - 8'd1) begin
            cnt_ff   <= 8'h00;
            tick_out <= 1'b1;
        end else begin
            cnt_ff   <= cnt_ff + 8'd1;
            tick_out <= 1'b0;
        end
    end
endmodule

// [nce_core.v]
// Purpose: Execute core for a subset of a 4-bit microcontroller instruction set.
// Assumes: Program memory answers rom_data_in for rom_addr_out within one machine cycle.
// Notes:   One machine cycle per tick; data memory and stack live inside this module.
`timescale 1ns/100ps
`include "nce_map.vh"
module nce_core #(
    parameter RAM_AW = 7
) (
    input  wire        clock_in,
    input  wire        nrst_in,
    input  wire [7:0]  rom_data_in,
    input  wire [15:0] flag_bits_in,
    input  wire        saved_carry_in,
    input  wire        saved_zero_in,
    input  wire        timer_overflow_in,
    input  wire        ext_request_in,
    input  wire [3:0]  port_pins_in,
    output wire [10:0] rom_addr_out,
    output wire [3:0]  accumulator_nibble_out,
    output wire [3:0]  extension_out,
    output wire [3:0]  pointer_high_nibble_out,
    output wire [3:0]  pointer_low_nibble_out,
    output wire        carry_flag_out,
    output wire        zero_flag_out,
    output wire        timer_overflow_flag_out,
    output wire        external_request_flag_out,
    output wire [3:0]  control_register_out,
    output wire [7:0]  timer_value_out,
    output wire        timer_load_out,
    output wire [3:0]  port_addr_out,
    output wire [3:0]  port_data_out,
    output wire        port_write_out
);
    localparam S_OP  = 1'b0;
    localparam S_TWO = 1'b1;

    wire        rst_n;
    wire        tick;
    wire [3:0]  pins_s;
    wire        req_s;
    reg         req_d_ff;
    reg         state_ff;
    reg  [7:0]  op_ff;
    reg  [10:0] pc_ff;
    reg  [10:0] rom_addr_ff;
    reg  [3:0]  ac_ff;
    reg  [3:0]  e_ff;
    reg  [3:0]  dph_ff;
    reg  [3:0]  dpl_ff;
    reg         cf_ff;
    reg         zf_ff;
    reg         tmf_ff;
    reg         external_request_flag_ff;
    reg  [3:0]  ctl_ff;
    reg  [7:0]  tm_ff;
    reg         tm_load_ff;
    reg  [3:0]  port_addr_ff;
    reg  [3:0]  port_data_ff;
    reg         port_wr_ff;
    reg         li_run_ff;
    reg  [1:0]  sp_ff;
    reg  [10:0] stack_mem [0:3];
    reg  [3:0]  ram_mem [0:(1<<RAM_AW)-1];
    reg  [3:0]  work_a [0:3];
    reg  [3:0]  work_h [0:1];
    reg  [3:0]  work_l [0:1];
    integer     i;

    // The pointer is eight bits wide; only the implemented memory depth is decoded.
    wire [7:0]  dp_full = {dph_ff, dpl_ff};
    wire [RAM_AW-1:0] ram_addr = dp_full[RAM_AW-1:0];
    wire [3:0]  mem_val = ram_mem[ram_addr];
    wire [7:0]  op      = rom_data_in;
    wire [10:0] pc_inc  = pc_ff + 11'd1;
    wire [10:0] pc_two  = pc_ff + 11'd2;
    wire [10:0] page_br = {pc_ff[10:8], rom_data_in};
    wire [3:0]  dpl_inc = dpl_ff + 4'd1;
    wire [3:0]  dpl_dec = dpl_ff - 4'd1;
    wire [3:0]  dph_xor = dph_ff ^ {1'b0, op_ff[2:0]};
    wire [3:0]  ctl_clr = ctl_ff & ~rom_data_in[3:0];
    wire [1:0]  sp_pop  = sp_ff - 2'd1;

    nce_sync #(.W(1), .RST(1'b0)) u_rst (
        .clk_in  (clock_in),
        .nrst_in (nrst_in),
        .d_in    (1'b1),
        .q_out   (rst_n)
    );

    nce_sync #(.W(5), .RST(1'b0)) u_pins (
        .clk_in  (clock_in),
        .nrst_in (rst_n),
        .d_in    ({ext_request_in, port_pins_in}),
        .q_out   ({req_s, pins_s})
    );

    nce_tick #(.DIV(`NCE_CYCLE_DIV)) u_tick (
        .clk_in   (clock_in),
        .nrst_in  (rst_n),
        .tick_out (tick)
    );

    // Taken branches stay in the current page.
    function taken_cond;
        input [7:0]  code;
        input [15:0] fl;
        input        tf;
        input        xf;
        input        cf;
        input        zf;
        begin
            casez (code)
                `NCE_OP_BFSET: taken_cond = fl[code[3:0]];
                `NCE_OP_BFCLR: taken_cond = ~fl[code[3:0]];
                `NCE_OP_BTSET: taken_cond = tf;
                `NCE_OP_BTCLR: taken_cond = ~tf;
                `NCE_OP_BRSET: taken_cond = xf;
                `NCE_OP_BRCLR: taken_cond = ~xf;
                `NCE_OP_BCSET: taken_cond = cf;
                `NCE_OP_BCCLR: taken_cond = ~cf;
                `NCE_OP_BZSET: taken_cond = zf;
                `NCE_OP_BZCLR: taken_cond = ~zf;
                default:       taken_cond = 1'b0;
            endcase
        end
    endfunction

    // Data memory has no reset, as the real array powers up undefined.
    always @(posedge clock_in) begin
        if (tick && state_ff == S_OP) begin
            casez (op)
                `NCE_OP_XMOD, `NCE_OP_XINC, `NCE_OP_XDEC: begin
                    ram_mem[ram_addr] <= ac_ff;
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= S_OP;
            op_ff        <= 8'h00;
            pc_ff        <= 11'h000;
            rom_addr_ff  <= 11'h000;
            ac_ff        <= 4'h0;
            e_ff         <= 4'h0;
            dph_ff       <= 4'h0;
            dpl_ff       <= 4'h0;
            cf_ff        <= 1'b0;
            zf_ff        <= 1'b0;
            tmf_ff       <= 1'b0;
            external_request_flag_ff      <= 1'b0;
            ctl_ff       <= 4'h0;
            tm_ff        <= 8'h00;
            tm_load_ff   <= 1'b0;
            port_addr_ff <= 4'h0;
            port_data_ff <= 4'h0;
            port_wr_ff   <= 1'b0;
            li_run_ff    <= 1'b0;
            sp_ff        <= 2'd0;
            req_d_ff     <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                stack_mem[i] <= 11'h000;
                work_a[i]    <= 4'h0;
            end
            for (i = 0; i < 2; i = i + 1) begin
                work_h[i] <= 4'h0;
                work_l[i] <= 4'h0;
            end
        end else begin
            tm_load_ff <= 1'b0;
            port_wr_ff <= 1'b0;
            req_d_ff   <= req_s;
            if (tick && state_ff == S_OP) begin
                op_ff       <= op;
                pc_ff       <= pc_inc;
                rom_addr_ff <= pc_inc;
                li_run_ff   <= 1'b0;
                casez (op)
                    `NCE_OP_LIMM: begin
                        li_run_ff <= 1'b1;
                        if (!li_run_ff) begin
                            ac_ff <= op[3:0];
                            zf_ff <= (op[3:0] == 4'h0);
                        end
                    end
                    `NCE_OP_LOAD: begin
                        ac_ff <= mem_val;
                        zf_ff <= (mem_val == 4'h0);
                    end
                    `NCE_OP_XMOD, `NCE_OP_XINC, `NCE_OP_XDEC: begin
                        ac_ff    <= mem_val;
                        state_ff <= S_TWO;
                    end
                    `NCE_OP_TABLE: begin
                        rom_addr_ff <= {pc_ff[10:8], e_ff, ac_ff};
                        state_ff    <= S_TWO;
                    end
                    `NCE_OP_LDZ: begin
                        dph_ff <= 4'h0;
                        dpl_ff <= op[3:0];
                    end
                    `NCE_OP_PINC: begin
                        dpl_ff <= dpl_inc;
                        zf_ff  <= (dpl_inc == 4'h0);
                    end
                    `NCE_OP_PDEC: begin
                        dpl_ff <= dpl_dec;
                        zf_ff  <= (dpl_dec == 4'h0);
                    end
                    `NCE_OP_XACC: begin
                        ac_ff            <= work_a[op[1:0]];
                        work_a[op[1:0]]  <= ac_ff;
                    end
                    `NCE_OP_XHIGH: begin
                        dph_ff        <= work_h[op[3]];
                        work_h[op[3]] <= dph_ff;
                    end
                    `NCE_OP_XLOW: begin
                        dpl_ff        <= work_l[op[3]];
                        work_l[op[3]] <= dpl_ff;
                    end
                    `NCE_OP_CJMP: begin
                        pc_ff       <= {pc_ff[10:8], e_ff, ac_ff};
                        rom_addr_ff <= {pc_ff[10:8], e_ff, ac_ff};
                    end
                    `NCE_OP_ZCALL: begin
                        stack_mem[sp_ff] <= pc_inc;
                        sp_ff            <= sp_ff + 2'd1;
                        pc_ff            <= {5'b00000, op[3:0], 2'b00};
                        rom_addr_ff      <= {5'b00000, op[3:0], 2'b00};
                    end
                    `NCE_OP_RET: begin
                        sp_ff       <= sp_pop;
                        pc_ff       <= stack_mem[sp_pop];
                        rom_addr_ff <= stack_mem[sp_pop];
                    end
                    `NCE_OP_RETI: begin
                        sp_ff       <= sp_pop;
                        pc_ff       <= stack_mem[sp_pop];
                        rom_addr_ff <= stack_mem[sp_pop];
                        cf_ff       <= saved_carry_in;
                        zf_ff       <= saved_zero_in;
                    end
                    `NCE_OP_PBSET, `NCE_OP_PBRST: begin
                        e_ff     <= pins_s;
                        state_ff <= S_TWO;
                    end
                    `NCE_OP_TWRITE: begin
                        tm_ff      <= {e_ff, ac_ff};
                        tm_load_ff <= 1'b1;
                        tmf_ff     <= 1'b0;
                    end
                    `NCE_OP_BFSET, `NCE_OP_BFCLR, `NCE_OP_LJMP, `NCE_OP_LCALL,
                    `NCE_OP_BTSET, `NCE_OP_BTCLR, `NCE_OP_BRSET, `NCE_OP_BRCLR,
                    `NCE_OP_BCSET, `NCE_OP_BCCLR, `NCE_OP_BZSET, `NCE_OP_BZCLR,
                    `NCE_OP_CSET, `NCE_OP_CRST: begin
                        state_ff <= S_TWO;
                    end
                    default: begin
                    end
                endcase
            end else if (tick) begin
                state_ff    <= S_OP;
                pc_ff       <= pc_inc;
                rom_addr_ff <= pc_inc;
                casez (op_ff)
                    `NCE_OP_XMOD: begin
                        pc_ff       <= pc_ff;
                        rom_addr_ff <= pc_ff;
                        dph_ff      <= dph_xor;
                        zf_ff       <= (dph_xor == 4'h0);
                    end
                    `NCE_OP_XINC: begin
                        pc_ff       <= pc_ff;
                        rom_addr_ff <= pc_ff;
                        dpl_ff      <= dpl_inc;
                        zf_ff       <= (dpl_inc == 4'h0);
                    end
                    `NCE_OP_XDEC: begin
                        pc_ff       <= pc_ff;
                        rom_addr_ff <= pc_ff;
                        dpl_ff      <= dpl_dec;
                        zf_ff       <= (dpl_dec == 4'h0);
                    end
                    `NCE_OP_TABLE: begin
                        pc_ff       <= pc_ff;
                        rom_addr_ff <= pc_ff;
                        e_ff        <= rom_data_in[7:4];
                        ac_ff       <= rom_data_in[3:0];
                    end
                    `NCE_OP_PBSET, `NCE_OP_PBRST: begin
                        pc_ff        <= pc_ff;
                        rom_addr_ff  <= pc_ff;
                        port_addr_ff <= dpl_ff;
                        port_wr_ff   <= 1'b1;
                        if (op_ff[5] == 1'b0) begin
                            port_data_ff <= e_ff | (4'h1 << op_ff[1:0]);
                        end else begin
                            port_data_ff <= e_ff & ~(4'h1 << op_ff[1:0]);
                            zf_ff        <= ((e_ff & ~(4'h1 << op_ff[1:0])) == 4'h0);
                        end
                    end
                    `NCE_OP_LJMP: begin
                        pc_ff       <= {op_ff[2:0], rom_data_in};
                        rom_addr_ff <= {op_ff[2:0], rom_data_in};
                    end
                    `NCE_OP_LCALL: begin
                        stack_mem[sp_ff] <= pc_inc;
                        sp_ff            <= sp_ff + 2'd1;
                        pc_ff            <= {op_ff[2:0], rom_data_in};
                        rom_addr_ff      <= {op_ff[2:0], rom_data_in};
                    end
                    `NCE_OP_CSET: begin
                        ctl_ff <= ctl_ff | rom_data_in[3:0];
                    end
                    `NCE_OP_CRST: begin
                        ctl_ff <= ctl_clr;
                        zf_ff  <= (ctl_clr == 4'h0);
                    end
                    default: begin
                        if (taken_cond(op_ff, flag_bits_in, tmf_ff, external_request_flag_ff, cf_ff, zf_ff)) begin
                            pc_ff       <= page_br;
                            rom_addr_ff <= page_br;
                        end
                        casez (op_ff)
                            `NCE_OP_BTSET, `NCE_OP_BTCLR: begin
                                tmf_ff <= 1'b0;
                            end
                            `NCE_OP_BRSET, `NCE_OP_BRCLR: begin
                                external_request_flag_ff <= 1'b0;
                            end
                            default: begin
                            end
                        endcase
                    end
                endcase
            end
            // A flag event arriving with a clear must not be lost.
            if (timer_overflow_in) begin
                tmf_ff <= 1'b1;
            end
            if (req_s && !req_d_ff) begin
                external_request_flag_ff <= 1'b1;
            end
        end
    end

    assign rom_addr_out              = rom_addr_ff;
    assign accumulator_nibble_out    = ac_ff;
    assign extension_out             = e_ff;
    assign pointer_high_nibble_out   = dph_ff;
    assign pointer_low_nibble_out    = dpl_ff;
    assign carry_flag_out            = cf_ff;
    assign zero_flag_out             = zf_ff;
    assign timer_overflow_flag_out   = tmf_ff;
    assign external_request_flag_out = external_request_flag_ff;
    assign control_register_out      = ctl_ff;
    assign timer_value_out           = tm_ff;
    assign timer_load_out            = tm_load_ff;
    assign port_addr_out             = port_addr_ff;
    assign port_data_out             = port_data_ff;
    assign port_write_out            = port_wr_ff;
endmodule

// [nce_core_sva.sv]
// Purpose: Port-level assertions for the nibble execute core.
// Assumes: Four clocks per machine cycle, as the core divider is built.
// Notes:   Bound to every nce_core instance below.
`timescale 1ns/100ps
module nce_core_sva (
    input wire        clock_in,
    input wire        nrst_in,
    input wire        timer_overflow_in,
    input wire [10:0] rom_addr_out,
    input wire [3:0]  accumulator_nibble_out,
    input wire [3:0]  extension_out,
    input wire [3:0]  pointer_low_nibble_out,
    input wire        timer_overflow_flag_out,
    input wire [7:0]  timer_value_out,
    input wire        timer_load_out,
    input wire [3:0]  port_addr_out,
    input wire [3:0]  port_data_out,
    input wire        port_write_out
);
default clocking @(posedge clock_in); endclocking
default disable iff (!nrst_in);
AST_TLOAD_PULSE: assert property (timer_load_out |=> !timer_load_out)
    else $error("timer load pulse too long");
AST_TLOAD_VALUE: assert property (timer_load_out |-> timer_value_out == {extension_out, accumulator_nibble_out})
    else $error("timer value differs from extension and accumulator");
AST_TLOAD_CLEAR: assert property (timer_load_out |-> !timer_overflow_flag_out || $past(timer_overflow_in))
    else $error("timer flag not cleared by timer write");
AST_TVAL_ONLY_LOAD: assert property ($changed(timer_value_out) |-> timer_load_out)
    else $error("timer value changed without load");
AST_TFLAG_SET: assert property (timer_overflow_in |=> timer_overflow_flag_out)
    else $error("timer overflow did not set flag");
AST_PWRITE_PULSE: assert property (port_write_out |=> !port_write_out)
    else $error("port write pulse too long");
AST_PWRITE_ADDR: assert property (port_write_out |-> port_addr_out == pointer_low_nibble_out)
    else $error("port address differs from pointer low nibble");
AST_PDATA_ONLY_WRITE: assert property ($changed(port_data_out) |-> port_write_out)
    else $error("port data changed without write");
AST_PC_CYCLE: assert property ($changed(rom_addr_out) |=> $stable(rom_addr_out) [*3])
    else $error("program address changed inside a machine cycle");
endmodule
bind nce_core nce_core_sva i_nce_core_sva (.clock_in(clock_in), .nrst_in(nrst_in),
    .timer_overflow_in(timer_overflow_in), .rom_addr_out(rom_addr_out),
    .accumulator_nibble_out(accumulator_nibble_out), .extension_out(extension_out),
    .pointer_low_nibble_out(pointer_low_nibble_out),
    .timer_overflow_flag_out(timer_overflow_flag_out), .timer_value_out(timer_value_out),
    .timer_load_out(timer_load_out), .port_addr_out(port_addr_out),
    .port_data_out(port_data_out), .port_write_out(port_write_out));

// [test_nibble_cpu_instruction_execute.sv]
// Purpose: Runs a short program through the execute core and checks its results.
// Assumes: Program bytes are served from a bench array at every falling edge.
// Notes:   Expected values come from integer bookkeeping of the program below.
`timescale 1ns/100ps
module test_nibble_cpu_instruction_execute;
reg         clock_in = 1'b0;
reg         nrst_in = 1'b0;
reg  [7:0]  rom_data_in = 8'h00;
reg  [15:0] flag_bits_in = 16'h0000;
reg         saved_carry_in = 1'b0;
reg         saved_zero_in = 1'b0;
reg         timer_overflow_in = 1'b0;
reg         ext_request_in = 1'b0;
reg  [3:0]  port_pins_in = 4'h0;
wire [10:0] rom_addr_out;
wire [3:0]  ac, ext, pointer_high_nibble, pointer_low_nibble, ctl, padr, pdat;
wire        cf, zf, timer_overflow_flag, xrf, tld, pwr;
wire [7:0]  tval;
reg  [7:0]  rom [0:2047];
integer     n_errors = 0;
integer     comparisons = 0;
integer     seed = 74095;
integer     i, exp_ac, exp_e;
always #12.5 clock_in = ~clock_in;
nce_core i_nce_core (.clock_in(clock_in), .nrst_in(nrst_in), .rom_data_in(rom_data_in),
    .flag_bits_in(flag_bits_in), .saved_carry_in(saved_carry_in),
    .saved_zero_in(saved_zero_in), .timer_overflow_in(timer_overflow_in),
    .ext_request_in(ext_request_in), .port_pins_in(port_pins_in),
    .rom_addr_out(rom_addr_out), .accumulator_nibble_out(ac), .extension_out(ext),
    .pointer_high_nibble_out(pointer_high_nibble), .pointer_low_nibble_out(pointer_low_nibble), .carry_flag_out(cf),
    .zero_flag_out(zf), .timer_overflow_flag_out(timer_overflow_flag), .external_request_flag_out(xrf),
    .control_register_out(ctl), .timer_value_out(tval), .timer_load_out(tld),
    .port_addr_out(padr), .port_data_out(pdat), .port_write_out(pwr));
always @(negedge clock_in) rom_data_in <= rom[rom_addr_out];
task end_of_test;
    begin
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
endtask
task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
        end
    end
endtask
// Bounded wait for the program address; a timeout ends the run.
task wait_addr(input [10:0] a);
    integer k;
    begin
        for (k = 0; k < 200 && rom_addr_out !== a; k = k + 1) @(negedge clock_in);
        check("pc", {5'h00, rom_addr_out}, {5'h00, a});
        if (rom_addr_out !== a) end_of_test;
    end
endtask
// Bounded wait for the one-clock port write strobe.
task wait_pwr;
    integer k;
    begin
        for (k = 0; k < 40 && pwr !== 1'b1; k = k + 1) @(negedge clock_in);
        check("pwr", {15'h0000, pwr}, 16'h0001);
        if (pwr !== 1'b1) end_of_test;
    end
endtask
initial begin
    for (i = 0; i < 2048; i = i + 1) rom[i] = 8'h00;
    port_pins_in = $random(seed);
    flag_bits_in = $random(seed) | 16'h0008;
    {saved_carry_in, saved_zero_in} = $random(seed);
    rom[0] = 8'hC5;
    rom[1] = 8'hC7;
    rom[2] = 8'h8A;
    rom[3] = 8'hEE;
    rom[4] = 8'hF9;
    rom[5] = 8'h68;
    rom[6] = 8'h10;
    rom[12] = 8'h62;
    rom[16] = 8'h7E;
    rom[17] = 8'h40;
    rom[18] = 8'h3E;
    rom[19] = 8'h20;
    rom[20] = 8'h42;
    rom[32] = 8'hB3;
    rom[33] = 8'h63;
    rom[34] = 8'hFA;
    rom[104] = 8'h05;
    rom[105] = 8'h7C;
    rom[106] = 8'h80;
    rom[128] = 8'hD3;
    rom[129] = 8'h90;
    rom[144] = 8'hB5;
    rom[145] = 8'h80;
    rom[146] = 8'hFE;
    rom[147] = 8'hFF;
    rom[148] = 8'h21;
    rom[149] = 8'hC3;
    rom[150] = 8'hA5;
    rom[151] = 8'hF4;
    rom[152] = 8'h21;
    rom[153] = 8'hE2;
    rom[154] = 8'hE2;
    rom[155] = 8'hEF;
    rom[156] = 8'h1C;
    rom[157] = 8'h06;
    rom[158] = 8'h2C;
    rom[159] = 8'h06;
    rom[160] = 8'h25;
    rom[161] = 8'h7D;
    rom[162] = 8'hC0;
    rom[192] = 8'hA8;
    rom[193] = 8'hD0;
    rom[208] = 8'h62;
    exp_ac = 5;
    repeat (4) @(negedge clock_in);
    nrst_in = 1'b1;
    wait_addr(11'h005);
    check("acc", ac, exp_ac);
    check("dph", pointer_high_nibble, 0);
    check("dpl", pointer_low_nibble, 4'hB);
    check("zf", zf, 0);
    wait_addr(11'h010);
    check("tval", tval, {4'h0, exp_ac[3:0]});
    check("tmf", timer_overflow_flag, 0);
    timer_overflow_in = 1'b1;
    @(negedge clock_in);
    timer_overflow_in = 1'b0;
    wait_addr(11'h012);
    wait_addr(11'h020);
    wait_addr(11'h00C);
    wait_addr(11'h021);
    wait_addr(11'h022);
    exp_e = rom[exp_ac] >> 4;
    exp_ac = rom[exp_ac] & 15;
    check("acc", ac, exp_ac);
    check("ext", ext, exp_e);
    wait_addr({3'h0, exp_e[3:0], exp_ac[3:0]});
    wait_pwr;
    check("padr", padr, 4'hB);
    check("pdat", pdat, port_pins_in | 4'h2);
    wait_addr(11'h080);
    check("tmf", timer_overflow_flag, 0);
    wait_addr(11'h090);
    wait_addr(11'h091);
    check("cf", cf, saved_carry_in);
    check("zf", zf, saved_zero_in);
    check("xrf", xrf, 0);
    ext_request_in = 1'b1;
    // Two-cycle exchanges move the address at their first tick, so wait out the second.
    wait_addr(11'h094);
    repeat (4) @(negedge clock_in);
    check("dpl", pointer_low_nibble, 0);
    check("zf", zf, 1);
    check("xrf", xrf, 1);
    wait_addr(11'h095);
    check("acc", ac, 8);
    check("zf", zf, 0);
    wait_addr(11'h097);
    repeat (4) @(negedge clock_in);
    check("acc", ac, 8);
    check("dph", pointer_high_nibble, 5);
    wait_addr(11'h098);
    check("dph", pointer_high_nibble, 0);
    wait_addr(11'h099);
    check("acc", ac, 3);
    wait_addr(11'h09A);
    check("acc", ac, 0);
    wait_addr(11'h09B);
    check("acc", ac, 3);
    wait_addr(11'h09C);
    check("dpl", pointer_low_nibble, 4'hF);
    wait_addr(11'h09E);
    check("ctl", ctl, 6);
    wait_addr(11'h0A0);
    check("ctl", ctl, 0);
    check("zf", zf, 1);
    wait_addr(11'h0A1);
    wait_pwr;
    check("padr", padr, 4'hF);
    check("pdat", pdat, port_pins_in & 4'hD);
    check("ext", ext, port_pins_in);
    wait_addr(11'h0C0);
    check("xrf", xrf, 0);
    wait_addr(11'h0D0);
    wait_addr(11'h0C2);
    end_of_test;
end
endmodule
